// ==== pkg/sob_pkg.sv ====
package sob_pkg;
	localparam int ADDR_W  = 13;
	localparam int ROW_W   = 13;
	localparam int COL32_W = 8;
	localparam int COL16_W = 9;
	localparam int DQ_W    = 32;
	localparam int HALF_W  = 16;
	localparam int MEM_AW  = 21;
	localparam int CLK_MHZ = 100;
	localparam int LAT_LOW_MHZ = 50;

	// Strobe patterns {ras_n, cas_n, mode_register_select_n}
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_RD  = 3'h5;

	// Mode code fields on the address bus
	localparam int MF_BL_LSB  = 0;
	localparam int MF_BT      = 3;
	localparam int MF_LAT_LSB = 4;

	localparam logic [2:0] MODE_LAT_RST = 3'h6;
	localparam logic       MODE_ILV_RST = 1'b0;
	localparam logic [2:0] MODE_BL_RST  = 3'h3;
	localparam logic [2:0] BL_CODE_MAX  = 3'h3;

	localparam logic [2:0] LAT_FAST_MIN = 3'h5;
	localparam logic [2:0] LAT_SLOW_MIN = 3'h4;
	localparam logic [2:0] LAT_MAX      = 3'h6;
	// Cycles taken by the final wait-to-burst edge, the array register and the output register
	localparam logic [2:0] PIPE_LAT     = 3'h3;

	typedef struct packed {
		logic [2:0] lat;
		logic       ilv;
		logic [2:0] bl;
	} sob_mode_t;

	typedef struct packed {
		logic valid;
		logic half;
		logic w16;
		logic first;
	} sob_beat_t;
endpackage

// ==== sim/sob_ctrl_model.sv ====
`timescale 1ns/1ps
module sob_ctrl_model (
	input  wire logic                       clk,
	output logic                            cke,
	output logic                            cs_n,
	output logic                            ras_n,
	output logic                            cas_n,
	output logic                            mode_register_select_n,
	output logic                            word_sel,
	output logic [sob_pkg::ADDR_W-1:0]      mux_address_bus
);
	import sob_pkg::*;
	initial begin
		cke = 1'b1;
		cs_n = 1'b1;
		{ras_n, cas_n, mode_register_select_n} = 3'h7;
		word_sel = 1'b0;
		mux_address_bus = 13'h0000;
	end
	// One command cycle; released address and word select show the inverse of what was driven
	task automatic issue(input logic [2:0] c, input logic [12:0] a, input logic w, input logic sn);
		@(posedge clk);
		#1;
		cke = 1'b1;
		cs_n = sn;
		{ras_n, cas_n, mode_register_select_n} = c;
		mux_address_bus = a;
		word_sel = w;
		@(posedge clk);
		#1;
		cs_n = 1'b1;
		{ras_n, cas_n, mode_register_select_n} = 3'h7;
		mux_address_bus = ~a;
		word_sel = ~w;
	endtask
	// Activate then read two edges later; never precharges or refreshes
	task automatic read_at(input logic [12:0] row, input logic [8:0] col, input logic w);
		issue(CMD_ACT, row, w, 1'b0);
		issue(CMD_RD, {4'h0, col}, w, 1'b0);
	endtask
	// Clock enable low for a number of edges, never across a command cycle
	task automatic hold_clock(input int cycles);
		cke = 1'b0;
		repeat (cycles) @(posedge clk);
		#1;
		cke = 1'b1;
	endtask
endmodule // sob_ctrl_model

// ==== sim/sob_read_tb.sv ====
`timescale 1ns/1ps
module sob_read_tb;
	import sob_pkg::*;
	localparam int AW = 10;
	typedef struct packed {
		logic [2:0]  lat;
		logic        ilv;
		logic [2:0]  bl;
		logic        w;
		logic [12:0] row;
		logic [8:0]  col;
	} sob_case_t;
	logic          clk = 1'b0;
	logic          rst_n = 1'b0;
	logic          static_operation_select = 1'b1;
	logic          dqm = 1'b0;
	logic          fill_we = 1'b0;
	logic [AW-1:0] fill_addr = '0;
	logic [31:0]   fill_data = '0;
	logic          cke, cs_n, ras_n, cas_n, mode_register_select_n, word_sel;
	logic [12:0]   mux_address_bus;
	logic [31:0]   data_out_bus;
	logic [15:0]   data_lo_oe_n, data_hi_oe_n;
	logic [2:0]    ml = 3'h6;
	logic          mi = 1'b0;
	logic [2:0]    mb = 3'h3;
	int            bad_count = 0;
	int            check_count = 0;
	sob_case_t rows [8] = '{
		'{3'h5, 1'b0, 3'h0, 1'b1, 13'h0001, 9'h013},
		'{3'h5, 1'b1, 3'h1, 1'b0, 13'h0002, 9'h025},
		'{3'h6, 1'b0, 3'h2, 1'b1, 13'h0003, 9'h0fe},
		'{3'h6, 1'b1, 3'h3, 1'b1, 13'h0000, 9'h0a5},
		'{3'h5, 1'b0, 3'h3, 1'b0, 13'h0001, 9'h1fb},
		'{3'h6, 1'b1, 3'h2, 1'b0, 13'h0002, 9'h006},
		'{3'h4, 1'b0, 3'h0, 1'b1, 13'h0003, 9'h031},
		'{3'h5, 1'b0, 3'h4, 1'b1, 13'h0000, 9'h07c}
	};
	always #5 clk = ~clk;
	sob_ctrl_model ctrl (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
		.mode_register_select_n(mode_register_select_n), .word_sel(word_sel),
		.mux_address_bus(mux_address_bus));
	sob_read #(.ARRAY_AW(AW)) dut (.clk(clk), .rst_n(rst_n),
		.static_operation_select(static_operation_select), .cke(cke), .cs_n(cs_n),
		.ras_n(ras_n), .cas_n(cas_n), .mode_register_select_n(mode_register_select_n),
		.dqm(dqm), .word_sel(word_sel), .mux_address_bus(mux_address_bus),
		.fill_we(fill_we), .fill_addr(fill_addr), .fill_data(fill_data),
		.data_out_bus(data_out_bus), .data_lo_oe_n(data_lo_oe_n),
		.data_hi_oe_n(data_hi_oe_n));
	function automatic logic [31:0] pat(input logic [AW-1:0] a);
		return {6'h2a, a, 6'h15, a};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic results();
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Mask index must be 3 or more, since dqm is raised three beats ahead
	// Stall index: clock enable drops for one edge after that beat, so the next beat stands twice
	task automatic burst(input logic [12:0] row, input logic [8:0] col, input logic w,
		input int mask, input int stall);
		logic [8:0] c;
		logic [AW-1:0] wa;
		logic [31:0] e;
		logic m;
		int n;
		n = 1 << mb;
		ctrl.read_at(row, col, w);
		repeat (ml) @(posedge clk);
		#1;
		for (int k = 0; k < n; k++) begin
			c = mi ? col ^ 9'(k) : (col & ~9'(n - 1)) | ((col + 9'(k)) & 9'(n - 1));
			wa = w ? {row[1:0], c[7:0]} : {row[1:0], c[8:1]};
			e = pat(wa);
			m = (k == mask);
			dqm = (k + 3 == mask);
			chk({16'h0, data_lo_oe_n}, m ? 32'h0000ffff : 32'h0);
			chk({16'h0, data_hi_oe_n}, (w && !m) ? 32'h0 : 32'h0000ffff);
			if (!m && w)
				chk(data_out_bus, e);
			if (!m && !w)
				chk({16'h0, data_out_bus[15:0]}, {16'h0, c[0] ? e[31:16] : e[15:0]});
			if (k == stall) begin
				ctrl.hold_clock(1);
			end
			@(posedge clk);
			#1;
		end
		dqm = 1'b0;
		chk({data_hi_oe_n, data_lo_oe_n}, 32'hffffffff);
	endtask
	initial begin
		repeat (8) @(posedge clk);
		#1;
		rst_n = 1'b1;
		for (int a = 0; a < (1 << AW); a++) begin
			@(posedge clk);
			#1;
			fill_we = 1'b1;
			fill_addr = a[AW-1:0];
			fill_data = pat(a[AW-1:0]);
		end
		@(posedge clk);
		#1;
		fill_we = 1'b0;
		ctrl.read_at(13'h0000, 9'h000, 1'b1);
		repeat (6) @(posedge clk);
		#1;
		chk({data_hi_oe_n, data_lo_oe_n}, 32'hffffffff);
		rst_n = 1'b0;
		static_operation_select = 1'b0;
		repeat (8) @(posedge clk);
		#1;
		chk(data_out_bus, 32'h0);
		chk({data_hi_oe_n, data_lo_oe_n}, 32'hffffffff);
		rst_n = 1'b1;
		burst(13'h0002, 9'h0c3, 1'b1, 99, 99);
		foreach (rows[i]) begin
			ctrl.issue(CMD_MRS, {6'h0, rows[i].lat, rows[i].ilv, rows[i].bl}, 1'b0, 1'b0);
			if (rows[i].lat >= LAT_FAST_MIN && rows[i].lat <= LAT_MAX && rows[i].bl <= BL_CODE_MAX) begin
				ml = rows[i].lat;
				mi = rows[i].ilv;
				mb = rows[i].bl;
			end
			burst(rows[i].row, rows[i].col, rows[i].w, 99, 99);
		end
		ctrl.issue(CMD_MRS, 13'h0053, 1'b0, 1'b0);
		ml = 3'h5;
		mi = 1'b0;
		mb = 3'h3;
		burst(13'h0001, 9'h044, 1'b1, 5, 99);
		burst(13'h0003, 9'h0a2, 1'b0, 99, 2);
		ctrl.issue(CMD_RD, 13'h0010, 1'b1, 1'b1);
		repeat (ml) @(posedge clk);
		#1;
		chk({data_hi_oe_n, data_lo_oe_n}, 32'hffffffff);
		results();
	end
	initial begin
		#50us;
		bad_count++;
		results();
	end
endmodule // sob_read_tb

// ==== verilog/sob_array.sv ====
`timescale 1ns/1ps
module sob_array #(
	parameter int AW = 21,
	parameter int DW = 32
) (
	input  wire logic          clk,
	input  wire logic          rd_en,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [DW-1:0] rd_data,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data
);
	logic [DW-1:0] cells [0:(1<<AW)-1];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			cells[wr_addr] <= wr_data;
		end
		if (rd_en) begin
			rd_data <= cells[rd_addr];
		end
	end
endmodule // sob_array

// ==== verilog/sob_read.sv ====
`timescale 1ns/1ps
module sob_read
	import sob_pkg::*;
#(
	parameter int CLK_FREQ_MHZ = sob_pkg::CLK_MHZ,
	parameter int ARRAY_AW     = sob_pkg::MEM_AW
) (
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      static_operation_select,
	input  wire logic                      cke,
	input  wire logic                      cs_n,
	input  wire logic                      ras_n,
	input  wire logic                      cas_n,
	input  wire logic                      mode_register_select_n,
	input  wire logic                      dqm,
	input  wire logic                      word_sel,
	input  wire logic [sob_pkg::ADDR_W-1:0] mux_address_bus,
	input  wire logic                      fill_we,
	input  wire logic [ARRAY_AW-1:0]       fill_addr,
	input  wire logic [sob_pkg::DQ_W-1:0]   fill_data,
	output logic      [sob_pkg::DQ_W-1:0]   data_out_bus,
	output logic      [sob_pkg::HALF_W-1:0] data_lo_oe_n,
	output logic      [sob_pkg::HALF_W-1:0] data_hi_oe_n
);
	import sob_pkg::*;

	generate
		if (ARRAY_AW < 1 || ARRAY_AW > MEM_AW) begin : g_bad_aw
			$error("ARRAY_AW out of range");
		end
	endgenerate

	typedef enum logic [2:0] {
		S_IDLE  = 3'b001,
		S_WAIT  = 3'b010,
		S_BURST = 3'b100
	} sob_state_t;

	function automatic logic [2:0] bl_mask(input logic [2:0] code);
		logic [2:0] m;
		m = 3'h0;
		for (int i = 0; i < 3; i++) begin
			if (code > 3'(i)) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction

	function automatic logic [COL16_W-1:0] burst_col(input logic [COL16_W-1:0] start,
		input logic [2:0] cnt, input logic ilv, input logic [2:0] m);
		logic [2:0] low;
		low = ilv ? (start[2:0] ^ cnt) : 3'(start[2:0] + cnt);
		return {start[COL16_W-1:3], (start[2:0] & ~m) | (low & m)};
	endfunction

	sob_state_t             state;
	sob_state_t             next_state;
	sob_mode_t              mode;
	sob_beat_t              mem_beat;
	logic                   en;
	logic [2:0]             wcnt;
	logic [2:0]             next_wcnt;
	logic [2:0]             bcnt;
	logic [2:0]             next_bcnt;
	logic [ROW_W-1:0]       row;
	logic [COL16_W-1:0]     col;
	logic                   w16;
	logic                   dqm_d1;
	logic                   dqm_d2;
	logic                   out_first;
	logic [2:0]             lat_cnt;
	logic [2:0]             rd_lat;
	logic [DQ_W-1:0]        rd_word;

	wire              sync_mode = !static_operation_select;
	wire              cmd_ok    = en && !cs_n && sync_mode;
	wire [2:0]        cmd       = {ras_n, cas_n, mode_register_select_n};
	wire              is_mrs    = cmd_ok && (cmd == CMD_MRS);
	wire              is_act    = cmd_ok && (cmd == CMD_ACT);
	wire              is_rd     = cmd_ok && (cmd == CMD_RD);
	wire [2:0]        lat_min   = (CLK_FREQ_MHZ <= LAT_LOW_MHZ) ? LAT_SLOW_MIN : LAT_FAST_MIN;
	wire [2:0]        new_lat   = mux_address_bus[MF_LAT_LSB +: 3];
	wire [2:0]        new_bl    = mux_address_bus[MF_BL_LSB +: 3];
	wire              mode_ok   = (new_lat >= lat_min) && (new_lat <= LAT_MAX)
		&& (new_bl <= BL_CODE_MAX);
	wire [2:0]        bmask     = bl_mask(mode.bl);
	wire              iss       = (state == S_BURST);
	wire [COL16_W-1:0] iss_col  = burst_col(col, bcnt, mode.ilv, bmask);
	// Word mode folds column bit zero into a half select of the 32-bit array
	wire [MEM_AW-1:0] wide_idx  = w16 ? {row, iss_col[COL16_W-1:1]}
		: {row, iss_col[COL32_W-1:0]};
	wire [ARRAY_AW-1:0] arr_idx = wide_idx[ARRAY_AW-1:0];
	wire              drive     = mem_beat.valid && !dqm_d2;
	wire [DQ_W-1:0]   out_word  = mem_beat.w16
		? {{HALF_W{1'b0}}, mem_beat.half ? rd_word[DQ_W-1:HALF_W] : rd_word[HALF_W-1:0]}
		: rd_word;

	always_comb begin
		next_state = state;
		next_wcnt  = wcnt;
		next_bcnt  = bcnt;
		if (!sync_mode) begin
			next_state = S_IDLE;
		end else if (is_rd) begin
			next_state = S_WAIT;
			next_wcnt  = 3'(mode.lat - PIPE_LAT);
			next_bcnt  = 3'h0;
		end else begin
			unique case (state)
				S_IDLE: begin
					next_bcnt = 3'h0;
				end
				S_WAIT: begin
					if (wcnt == 3'h0) begin
						next_state = S_BURST;
					end else begin
						next_wcnt = 3'(wcnt - 3'h1);
					end
				end
				S_BURST: begin
					if (bcnt == bmask) begin
						next_state = S_IDLE;
					end
					next_bcnt = 3'(bcnt + 3'h1);
				end
				default: begin
					next_state = S_IDLE;
				end
			endcase
		end
	end

	// Clock enable sampled now gates the following edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en <= 1'b1;
		end else begin
			en <= cke;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= S_IDLE;
			wcnt  <= 3'h0;
			bcnt  <= 3'h0;
		end else if (en || !sync_mode) begin
			state <= next_state;
			wcnt  <= next_wcnt;
			bcnt  <= next_bcnt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= '{lat: MODE_LAT_RST, ilv: MODE_ILV_RST, bl: MODE_BL_RST};
		end else if (is_mrs && mode_ok) begin
			mode.lat <= new_lat;
			mode.ilv <= mux_address_bus[MF_BT];
			mode.bl  <= new_bl;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			row <= '0;
			col <= '0;
			w16 <= 1'b0;
		end else begin
			if (is_act) begin
				row <= mux_address_bus;
			end
			if (is_rd) begin
				w16 <= !word_sel;
				col <= word_sel ? {1'b0, mux_address_bus[COL32_W-1:0]}
					: mux_address_bus[COL16_W-1:0];
			end
		end
	end

	sob_array #(
		.AW (ARRAY_AW),
		.DW (DQ_W)
	) u_array (
		.clk     (clk),
		.rd_en   (en && iss),
		.rd_addr (arr_idx),
		.rd_data (rd_word),
		.wr_en   (fill_we && static_operation_select),
		.wr_addr (fill_addr),
		.wr_data (fill_data)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_beat <= '0;
			dqm_d1   <= 1'b0;
			dqm_d2   <= 1'b0;
		end else if (en) begin
			mem_beat <= '{valid: iss && sync_mode, half: iss_col[0], w16: w16,
				first: bcnt == 3'h0};
			dqm_d1   <= dqm;
			dqm_d2   <= dqm_d1;
		end
	end

	// Output stage; static mode releases the pins on the next edge, whatever the clock enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			data_out_bus <= '0;
			data_lo_oe_n <= '1;
			data_hi_oe_n <= '1;
		end else if (!sync_mode) begin
			data_lo_oe_n <= '1;
			data_hi_oe_n <= '1;
		end else if (en) begin
			data_out_bus <= out_word;
			data_lo_oe_n <= {HALF_W{!drive}};
			data_hi_oe_n <= {HALF_W{!(drive && !mem_beat.w16)}};
		end
	end

	// Latency bookkeeping watched by the checks below
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_first <= 1'b0;
			lat_cnt   <= 3'h0;
			rd_lat    <= MODE_LAT_RST;
		end else if (en) begin
			out_first <= mem_beat.valid && mem_beat.first;
			if (is_rd) begin
				lat_cnt <= 3'h0;
				rd_lat  <= mode.lat;
			end else if (lat_cnt != 3'h7) begin
				lat_cnt <= 3'(lat_cnt + 3'h1);
			end
		end
	end

	latency_first_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(out_first) |-> (lat_cnt == rd_lat) || (lat_cnt == 3'(rd_lat + 3'h1)))
		else $error("first burst word not at read latency");

	idle_hiz_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$past(en) && !$past(mem_beat.valid) |-> &data_lo_oe_n && &data_hi_oe_n)
		else $error("data driven outside a read data cycle");

	mask_two_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$past(dqm && en, 3) && $past(en, 2) && $past(en, 1) |->
			&data_lo_oe_n && &data_hi_oe_n)
		else $error("mask did not suppress data two cycles later");

	static_hiz_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		$past(static_operation_select) |-> &data_lo_oe_n && &data_hi_oe_n)
		else $error("data driven in static mode");

	cs_ignore_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		cs_n |=> $stable(mode) && $stable(row))
		else $error("command taken while chip select high");

	freeze_state_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!en && sync_mode |=> $stable(state) && $stable(data_out_bus) && $stable(bcnt))
		else $error("state moved while clock suspended");

	upper_hiz_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		!data_hi_oe_n[0] |-> !data_lo_oe_n[0] && $past(!mem_beat.w16))
		else $error("upper outputs driven in word mode");

	seq_order_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		iss && en && $past(iss && en) && !$past(is_rd) && !mode.ilv && $stable(mode)
		|-> (iss_col[2:0] & bmask) == (3'($past(iss_col[2:0]) + 3'h1) & bmask))
		else $error("sequential burst order broken");

	ilv_order_a: assert property (
		@(posedge clk) disable iff (!rst_n)
		iss && en && mode.ilv |-> (iss_col[2:0] & bmask) == ((col[2:0] ^ bcnt) & bmask))
		else $error("interleaved burst order broken");
endmodule // sob_read
